// ===== core/ihs_pkg.sv
// Shared constants and types for the ISA host-side signalling block
package ihs_pkg;

  // Documented widths and counts
  localparam int IHS_SLOTS         = 2;   // Card slots behind the adapter
  localparam int IHS_IRQ_LINES     = 10;  // Interrupt request outputs
  localparam int IHS_DATA_W        = 16;  // System data bus width
  localparam int IHS_CHECK_PERIODS = 3;   // Channel-check pulse, in ISA clock periods
  localparam int IHS_WAIT_PERIODS  = 1;   // Register-selected wait, in ISA clock periods

  // Values after reset
  localparam logic       IHS_BASE_SEL_RST = 1'b0;
  localparam logic [2:0] IHS_CNT_RST      = 3'h0;
  localparam logic [1:0] IHS_LANES_RST    = 2'h0;

  // Host interrupt numbers carried by irq_req[0] .. irq_req[9]
  localparam logic [3:0] IHS_IRQ_NUM [IHS_IRQ_LINES] = '{
    4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf
  };

  // Host bus strobes, all as seen on the ISA pins
  typedef struct packed {
    logic memr_n;   // Memory read, active low
    logic memw_n;   // Memory write, active low
    logic ior_n;    // I/O read, active low
    logic iow_n;    // I/O write, active low
    logic aen;      // Address enable, high during DMA
    logic sbhe_n;   // Byte-high enable, active low
  } ihs_strobe_t;

  // Per-slot status from the card side
  typedef struct packed {
    logic mem_wide;  // Card window is 16-bit memory
    logic io_wide;   // Card window is 16-bit I/O
    logic wait_n;    // Card asks for a wait, active low
    logic spkr_n;    // Card digital audio, active low
    logic irq;       // Card interrupt, active high
  } ihs_card_t;

  // Host cycle sequencer, Gray along idle-wait-transfer-end
  typedef enum logic [1:0] {
    IHS_IDLE = 2'b00,
    IHS_WAIT = 2'b01,
    IHS_XFER = 2'b11,
    IHS_END  = 2'b10
  } ihs_state_t;

endpackage : ihs_pkg

// ===== core/ihs_check_pulse.sv
// Channel-check pulse generator timed in ISA clock periods
`timescale 1ns/1ps
module ihs_check_pulse
  import ihs_pkg::*;
#(
  parameter int PERIODS = IHS_CHECK_PERIODS
) (
  input  logic sys_clk,
  input  logic arst_n,
  input  logic sreset,
  input  logic sclk_rise,
  input  logic req,
  output logic check_n
);

  initial begin
    if (PERIODS < 1 || PERIODS > 7) $error("ihs_check_pulse: PERIODS must be 1..7");
  end

  // The pulse ends on the rise that closes its last period
  localparam logic [2:0] LAST = 3'(PERIODS - 1);

  logic       pend_reg;
  logic       pend_next;
  logic       busy_reg;
  logic       busy_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       check_n_next;

  // A request waits for the next ISA clock rise so the low time is whole periods
  assign pend_next    = sreset ? 1'b0 : (req || (pend_reg && !(sclk_rise && !busy_reg)));
  assign busy_next    = sreset ? 1'b0 :
                        (!busy_reg ? (pend_reg && sclk_rise) : !(sclk_rise && cnt_reg == LAST));
  assign cnt_next     = (!busy_reg || sreset) ? IHS_CNT_RST :
                        (sclk_rise ? cnt_reg + 3'h1 : cnt_reg);
  // Low from the starting rise to the PERIODS-th rise after it  // see RULE_15
  assign check_n_next = !busy_next;                              // see RULE_14

  // Registers; requests during a pulse queue one more pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      cnt_reg  <= IHS_CNT_RST;
      check_n  <= 1'b1;
    end else begin
      pend_reg <= pend_next;
      busy_reg <= busy_next;
      cnt_reg  <= cnt_next;
      check_n  <= check_n_next;
    end
  end

endmodule : ihs_check_pulse

// ===== core/ihs_host_port.sv
// ISA host-side strobes, open-drain indications, interrupts and speaker pin
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Pull 16-bit I/O select low for a 16-bit I/O card.
// RULE_02: Hold channel ready low while a cycle waits.
// RULE_03: Signal 16-bit memory select for a 16-bit memory card.
// RULE_04: Memory write strobe low forwards a write to the card.
// RULE_05: Memory read strobe low returns card data.
// RULE_06: Byte-high enable low selects the upper byte lane.
// RULE_07: During system reset, sample the shared pin as base select.
// RULE_08: Outside reset, drive the shared pin as speaker output.
// RULE_09: Speaker output carries card digital audio to the host.
// RULE_10: Pull no-wait low for an access without wait states.
// RULE_11: Never no-wait in 16-bit I/O cycles; otherwise only when enabled.
// RULE_12: Ten active-high interrupt outputs for host lines 3-5, 7, 9-12, 14-15.
// RULE_13: Each slot interrupt goes to exactly one selected output; a slot that selects an unlisted number drives none.
// RULE_14: Drive channel check low to request a non-maskable interrupt.
// RULE_15: Each channel-check pulse lasts three ISA clock periods.
// RULE_16: Selected wait holds channel ready low one ISA clock period.
// RULE_17: Host holds system reset high; base select is sampled then.
// RULE_18: Ignore strobes while address enable is high (DMA).
module ihs_host_port
  import ihs_pkg::*;
#(
  parameter int SLOTS        = IHS_SLOTS,
  parameter int WAIT_PERIODS = IHS_WAIT_PERIODS,
  parameter int SLOT_W       = $clog2(IHS_SLOTS)
) (
  input  logic                     sys_clk,
  input  logic                     arst_n,
  input  logic                     system_reset_in,
  input  logic                     sclk,
  input  ihs_strobe_t              strobe,
  input  logic [IHS_DATA_W-1:0]    sys_d_i,
  output logic [IHS_DATA_W-1:0]    sys_d_o,
  output logic                     sys_d_oe,
  input  logic                     hit,
  input  logic                     hit_io,
  input  logic [SLOT_W-1:0]        hit_slot,
  input  logic                     addr_odd,
  input  logic                     io_wide_select_n_i,
  output logic                     io_wide_select_n_o,
  output logic                     io_wide_select_n_oe,
  input  logic                     channel_ready_i,
  output logic                     channel_ready_o,
  output logic                     channel_ready_oe,
  input  logic                     mem_wide_select_i,
  output logic                     mem_wide_select_o,
  output logic                     mem_wide_select_oe,
  input  logic                     zero_wait_n_i,
  output logic                     zero_wait_n_o,
  output logic                     zero_wait_n_oe,
  input  logic                     speaker_or_base_select_i,
  output logic                     speaker_or_base_select_o,
  output logic                     speaker_or_base_select_oe,
  output logic [IHS_IRQ_LINES-1:0] irq_req,
  output logic                     channel_check_n,
  output logic                     base_select,
  input  logic                     zero_wait_en,
  input  logic                     wait_state_en,
  input  logic [SLOTS-1:0][3:0]    irq_sel,
  input  logic [SLOTS-1:0]         speaker_en,
  input  logic                     check_req,
  input  ihs_card_t [SLOTS-1:0]    card,
  input  logic [IHS_DATA_W-1:0]    card_rdata,
  output logic [IHS_DATA_W-1:0]    card_wdata,
  output logic                     card_rd,
  output logic                     card_wr,
  output logic [1:0]               card_byte_en,
  output logic [SLOT_W-1:0]        card_slot
);

  initial begin
    if (SLOTS < 2 || SLOTS > 8) $error("ihs_host_port: SLOTS must be 2..8");
    if (SLOT_W != $clog2(SLOTS)) $error("ihs_host_port: SLOT_W must be clog2(SLOTS)");
    if (WAIT_PERIODS < 1 || WAIT_PERIODS > 6) $error("ihs_host_port: WAIT_PERIODS 1..6");
  end

  // One rise aligns to the ISA clock, the rest measure whole periods
  localparam logic [2:0] WAIT_RISES = 3'(WAIT_PERIODS + 1);

  //////////////////////////////////////////////////////////////////////////////
  // ISA clock edge and strobe decode

  logic        sclk_prev_reg;
  logic        sclk_rise;
  logic        mem_rd;
  logic        mem_wr;
  logic        io_rd;
  logic        io_wr;
  logic        any_rd;
  logic        any_wr;
  logic        start;
  ihs_card_t   sel_card;

  // Pins are synchronous to sys_clk, so one stage is enough for the edge
  assign sclk_rise = sclk && !sclk_prev_reg;

  // DMA cycles carry address enable high and never belong to the adapter
  assign mem_rd   = !strobe.memr_n && !hit_io && !strobe.aen;   // see RULE_05, RULE_18
  assign mem_wr   = !strobe.memw_n && !hit_io && !strobe.aen;   // see RULE_04, RULE_18
  assign io_rd    = !strobe.ior_n && hit_io && !strobe.aen;     // see RULE_18
  assign io_wr    = !strobe.iow_n && hit_io && !strobe.aen;     // see RULE_18
  assign any_rd   = mem_rd || io_rd;
  assign any_wr   = mem_wr || io_wr;
  assign start    = hit && (any_rd || any_wr);
  assign sel_card = card[hit_slot];

  //////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  ihs_state_t       state_reg;
  ihs_state_t       state_next;
  logic [2:0]       rise_cnt_reg;
  logic [2:0]       rise_cnt_next;
  logic             cyc_rd_reg;
  logic             cyc_rd_next;
  logic             cyc_wr_reg;
  logic             cyc_wr_next;
  logic             cyc_io16_reg;
  logic             cyc_io16_next;
  logic             waited_reg;
  logic             waited_next;
  logic [1:0]       lanes_reg;
  logic [1:0]       lanes_next;
  logic [SLOT_W-1:0] slot_reg;
  logic [SLOT_W-1:0] slot_next;
  logic             need_wait;
  logic             wait_done;
  logic             strobe_gone;

  // Register-selected wait or a card asking for one both stretch the cycle
  assign need_wait   = wait_state_en || !sel_card.wait_n;                 // see RULE_16
  assign wait_done   = (!wait_state_en || rise_cnt_reg >= WAIT_RISES) &&
                       card[slot_reg].wait_n;                              // see RULE_02
  assign strobe_gone = !(cyc_rd_reg ? any_rd : any_wr);

  // Next state; system reset abandons any cycle
  always_comb begin
    state_next = state_reg;
    if (system_reset_in) begin
      state_next = IHS_IDLE;
    end else begin
      unique case (state_reg)
        IHS_IDLE: if (start) state_next = need_wait ? IHS_WAIT : IHS_XFER;
        IHS_WAIT: begin
          if (strobe_gone)    state_next = IHS_END;
          else if (wait_done) state_next = IHS_XFER;
        end
        IHS_XFER: if (strobe_gone) state_next = IHS_END;
        IHS_END:  state_next = IHS_IDLE;
      endcase
    end
  end

  // Attributes freeze at the start so the card sees a stable request
  wire take = (state_reg == IHS_IDLE) && start && !system_reset_in;
  assign cyc_rd_next   = take ? any_rd : cyc_rd_reg;
  assign cyc_wr_next   = take ? (any_wr && !any_rd) : cyc_wr_reg;
  assign cyc_io16_next = take ? (hit_io && sel_card.io_wide) : cyc_io16_reg;
  assign waited_next   = take ? need_wait : waited_reg;
  assign slot_next     = take ? hit_slot : slot_reg;
  // Low lane for even addresses, high lane when byte-high enable is low
  assign lanes_next    = take ? {!strobe.sbhe_n, !addr_odd} : lanes_reg;   // see RULE_06
  assign rise_cnt_next = (state_reg != IHS_WAIT) ? IHS_CNT_RST :
                         (sclk_rise && rise_cnt_reg != 3'h7) ? rise_cnt_reg + 3'h1 :
                         rise_cnt_reg;

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= IHS_IDLE;
      rise_cnt_reg  <= IHS_CNT_RST;
      sclk_prev_reg <= 1'b0;
      cyc_rd_reg    <= 1'b0;
      cyc_wr_reg    <= 1'b0;
      cyc_io16_reg  <= 1'b0;
      waited_reg    <= 1'b0;
      lanes_reg     <= IHS_LANES_RST;
      slot_reg      <= '0;
    end else begin
      state_reg     <= state_next;
      rise_cnt_reg  <= rise_cnt_next;
      sclk_prev_reg <= sclk;
      cyc_rd_reg    <= cyc_rd_next;
      cyc_wr_reg    <= cyc_wr_next;
      cyc_io16_reg  <= cyc_io16_next;
      waited_reg    <= waited_next;
      lanes_reg     <= lanes_next;
      slot_reg      <= slot_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus-side indications, all registered; ready and no-wait from next-state terms, widths from address decode

  logic ready_oe_next;
  logic io_wide_oe_next;
  logic mem_wide_oe_next;
  logic zero_wait_oe_next;
  logic xfer_next;

  assign xfer_next        = (state_next == IHS_XFER);
  assign ready_oe_next    = (state_next == IHS_WAIT);                     // see RULE_02, RULE_16
  // Address decode alone drives the width pins, ahead of the strobes
  assign io_wide_oe_next  = !system_reset_in && hit && hit_io && !strobe.aen &&
                            sel_card.io_wide;                              // see RULE_01
  // Open drain: 16-bit shown by release, 8-bit by pull-low
  assign mem_wide_oe_next = !system_reset_in && hit && !hit_io && !strobe.aen &&
                            !sel_card.mem_wide;                            // see RULE_03
  assign zero_wait_oe_next = xfer_next && zero_wait_en && !cyc_io16_next &&
                             !waited_next;                                 // see RULE_10, RULE_11

  // Open-drain pins only ever pull low
  assign io_wide_select_n_o = 1'b0;
  assign channel_ready_o    = 1'b0;
  assign mem_wide_select_o  = 1'b0;
  assign zero_wait_n_o      = 1'b0;

  // Enable flops for the open-drain pins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_ready_oe    <= 1'b0;
      io_wide_select_n_oe <= 1'b0;
      mem_wide_select_oe  <= 1'b0;
      zero_wait_n_oe      <= 1'b0;
    end else begin
      channel_ready_oe    <= ready_oe_next;
      io_wide_select_n_oe <= io_wide_oe_next;
      mem_wide_select_oe  <= mem_wide_oe_next;
      zero_wait_n_oe      <= zero_wait_oe_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Card-side request and data path

  logic card_rd_next;
  logic card_wr_next;

  assign card_rd_next = xfer_next && cyc_rd_next;   // see RULE_05
  assign card_wr_next = xfer_next && cyc_wr_next;   // see RULE_04

  // Data drive is dropped one cycle after the strobe to avoid bus contention
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      card_rd      <= 1'b0;
      card_wr      <= 1'b0;
      card_byte_en <= IHS_LANES_RST;
      card_slot    <= '0;
      card_wdata   <= '0;
      sys_d_o      <= '0;
      sys_d_oe     <= 1'b0;
    end else begin
      card_rd      <= card_rd_next;
      card_wr      <= card_wr_next;
      card_byte_en <= (card_rd_next || card_wr_next) ? lanes_next : IHS_LANES_RST; // see RULE_06
      card_slot    <= slot_next;
      card_wdata   <= sys_d_i;                       // see RULE_04
      sys_d_o      <= card_rdata;                    // see RULE_05
      sys_d_oe     <= card_rd_next;                  // see RULE_05
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt routing

  logic [IHS_IRQ_LINES-1:0] irq_next;
  logic [SLOTS-1:0]         spk_bits;

  // A slot matches only the line whose number it selects; others stay off
  for (genvar gi = 0; gi < IHS_IRQ_LINES; gi++) begin : g_irq
    logic [SLOTS-1:0] match;
    for (genvar gs = 0; gs < SLOTS; gs++) begin : g_slot
      assign match[gs] = card[gs].irq && (irq_sel[gs] == IHS_IRQ_NUM[gi]); // see RULE_13
    end
    assign irq_next[gi] = |match;                                          // see RULE_12
  end

  // Audio from enabled slots is mixed by exclusive-or, as on a PC speaker line
  for (genvar gs = 0; gs < SLOTS; gs++) begin : g_spk
    assign spk_bits[gs] = speaker_en[gs] && !card[gs].spkr_n;             // see RULE_09
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared speaker / base-select pin and interrupts

  // Base select follows the pin through the reset window and holds its last value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      base_select               <= IHS_BASE_SEL_RST;
      speaker_or_base_select_oe <= 1'b0;
      speaker_or_base_select_o  <= 1'b0;
      irq_req                   <= '0;
    end else begin
      if (system_reset_in) begin
        base_select <= speaker_or_base_select_i;                // see RULE_07, RULE_17
      end
      speaker_or_base_select_oe <= !system_reset_in;            // see RULE_07, RULE_08
      speaker_or_base_select_o  <= !system_reset_in && (^spk_bits); // see RULE_08, RULE_09
      irq_req                   <= system_reset_in ? '0 : irq_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Non-maskable channel check

  ihs_check_pulse #(
    .PERIODS (IHS_CHECK_PERIODS)
  ) u_check (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .sreset    (system_reset_in),
    .sclk_rise (sclk_rise),
    .req       (check_req),
    .check_n   (channel_check_n)
  );

endmodule : ihs_host_port

// ===== sim/ihs_host_port_assertions.sv
// Concurrent checks on the host-side signalling ports
`timescale 1ns/1ps
module ihs_host_port_assertions
  import ihs_pkg::*;
#(
  parameter int SLOTS        = IHS_SLOTS,
  parameter int WAIT_PERIODS = IHS_WAIT_PERIODS,
  parameter int SLOT_W       = $clog2(IHS_SLOTS)
) (
  input logic                     sys_clk,
  input logic                     arst_n,
  input logic                     system_reset_in,
  input logic                     sclk,
  input ihs_strobe_t              strobe,
  input logic                     hit,
  input logic                     hit_io,
  input logic [SLOT_W-1:0]        hit_slot,
  input logic                     io_wide_select_n_oe,
  input logic                     channel_ready_oe,
  input logic                     mem_wide_select_oe,
  input logic                     zero_wait_n_oe,
  input logic                     speaker_or_base_select_i,
  input logic                     speaker_or_base_select_o,
  input logic                     speaker_or_base_select_oe,
  input logic [IHS_IRQ_LINES-1:0] irq_req,
  input logic                     channel_check_n,
  input logic                     base_select,
  input logic                     zero_wait_en,
  input logic [SLOTS-1:0][3:0]    irq_sel,
  input logic [SLOTS-1:0]         speaker_en,
  input ihs_card_t [SLOTS-1:0]    card,
  input logic                     card_rd,
  input logic                     card_wr
);
  localparam int RDY_MAX = WAIT_PERIODS + 1;
  logic                     sclk_q;
  logic                     up_q;
  logic                     rise;
  logic [3:0]               chk_cnt;
  logic [3:0]               rdy_cnt;
  logic [IHS_IRQ_LINES-1:0] exp_irq;
  logic                     exp_spk;
  logic                     wait_hi;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n || system_reset_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Expected routing; unlisted numbers match nothing
  assign rise = sclk & ~sclk_q;
  always_comb begin
    exp_irq = '0;
    exp_spk = 1'b0;
    wait_hi = 1'b1;
    for (int s = 0; s < SLOTS; s++) begin
      for (int i = 0; i < IHS_IRQ_LINES; i++) begin
        exp_irq[i] = exp_irq[i] | (card[s].irq & (irq_sel[s] == IHS_IRQ_NUM[i]));
      end
      exp_spk = exp_spk ^ (speaker_en[s] & ~card[s].spkr_n);
      wait_hi = wait_hi & card[s].wait_n;
    end
  end
  // Rise counts restart when pulse or wait stops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q  <= 1'b0;
      up_q    <= 1'b0;
      chk_cnt <= 4'h0;
      rdy_cnt <= 4'h0;
    end else begin
      sclk_q  <= sclk;
      up_q    <= 1'b1;
      chk_cnt <= channel_check_n ? 4'h0 : chk_cnt + {3'h0, rise};
      rdy_cnt <= (!channel_ready_oe || !wait_hi) ? 4'h0 : rdy_cnt + {3'h0, rise};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_IO_WIDE: assert property (
    !$past(system_reset_in) |-> io_wide_select_n_oe ==
      $past(hit && hit_io && !strobe.aen && card[hit_slot].io_wide))
    else $error("io width wrong");
  AST_MEM_WIDE: assert property (
    !$past(system_reset_in) |-> mem_wide_select_oe ==
      $past(hit && !hit_io && !strobe.aen && !card[hit_slot].mem_wide))
    else $error("mem width wrong");
  AST_RDY_HOLD: assert property (channel_ready_oe |-> !card_rd && !card_wr)
    else $error("access while held");
  AST_RDY_LEN: assert property (channel_ready_oe && wait_hi |-> rdy_cnt <= RDY_MAX)
    else $error("wait too long");
  AST_ZW: assert property (
    $rose(zero_wait_n_oe) |-> $past(zero_wait_en) && !io_wide_select_n_oe && !channel_ready_oe)
    else $error("bad no-wait");
  AST_AEN: assert property (
    strobe.aen && !card_rd && !card_wr && !channel_ready_oe |=> !card_rd && !card_wr)
    else $error("access during aen");
  AST_CHECK_LEN: assert property ($rose(channel_check_n) |-> chk_cnt == IHS_CHECK_PERIODS)
    else $error("check length wrong");
  AST_IRQ: assert property (!$past(system_reset_in) |-> irq_req == $past(exp_irq))
    else $error("irq wrong");
  AST_SPK_VAL: assert property (
    speaker_or_base_select_oe |-> speaker_or_base_select_o == $past(exp_spk))
    else $error("speaker wrong");
  AST_SPK_OE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    up_q |-> speaker_or_base_select_oe == !$past(system_reset_in))
    else $error("pin direction wrong");
  AST_BASE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    up_q && $past(system_reset_in) |-> base_select == $past(speaker_or_base_select_i))
    else $error("base select wrong");
endmodule : ihs_host_port_assertions

// ===== sim/ihs_isa_host.sv
// Host-system model: free-running ISA clock and pull-ups on the shared pins
`timescale 1ns/1ps
module ihs_isa_host
  import ihs_pkg::*;
(
  input  logic sys_clk,
  input  logic system_reset_in,
  input  logic strap,
  input  logic io_oe,
  input  logic rdy_oe,
  input  logic mem_oe,
  input  logic zw_oe,
  input  logic spk_o,
  input  logic spk_oe,
  output logic sclk,
  output logic io_lvl,
  output logic rdy_lvl,
  output logic mem_lvl,
  output logic zw_lvl,
  output logic spk_lvl
);
  logic [1:0] div_reg;
  // Free-running ISA clock at one eighth of sys_clk
  initial begin
    sclk    = 1'b0;
    div_reg = 2'h0;
  end
  always @(posedge sys_clk) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) begin
      sclk <= ~sclk;
    end
  end
  // Pull-ups: a released open-drain line reads high
  assign io_lvl  = !io_oe;
  assign rdy_lvl = !rdy_oe;
  assign mem_lvl = !mem_oe;
  assign zw_lvl  = !zw_oe;
  // Strap drives the shared pin only in reset
  assign spk_lvl = spk_oe ? spk_o : (system_reset_in ? strap : 1'b1);
endmodule : ihs_isa_host

// ===== sim/testbench.sv
// Self-checking testbench for the host-side signalling block
`timescale 1ns/1ps
module testbench
  import ihs_pkg::*;
;
  localparam ihs_strobe_t SB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic sys_clk, arst_n, system_reset_in, sclk, hit, hit_io, addr_odd, sys_d_oe, strap;
  logic zero_wait_en, wait_state_en, check_req, channel_check_n, base_select;
  logic io_wide_select_n_i, io_wide_select_n_o, io_wide_select_n_oe;
  logic channel_ready_i, channel_ready_o, channel_ready_oe;
  logic mem_wide_select_i, mem_wide_select_o, mem_wide_select_oe;
  logic zero_wait_n_i, zero_wait_n_o, zero_wait_n_oe, card_rd, card_wr;
  logic speaker_or_base_select_i, speaker_or_base_select_o, speaker_or_base_select_oe;
  logic [0:0] hit_slot, card_slot;
  logic [1:0] speaker_en, card_byte_en;
  logic [1:0][3:0] irq_sel;
  logic [9:0] irq_req;
  logic [15:0] sys_d_i, sys_d_o, card_rdata, card_wdata;
  ihs_strobe_t strobe;
  ihs_card_t [1:0] card;
  logic zw, rdy;
  int fail_count, n_tests;
  ihs_host_port i_dut (.*);
  ihs_isa_host i_host (.sys_clk(sys_clk), .system_reset_in(system_reset_in), .strap(strap),
    .io_oe(io_wide_select_n_oe), .rdy_oe(channel_ready_oe), .mem_oe(mem_wide_select_oe),
    .zw_oe(zero_wait_n_oe), .spk_o(speaker_or_base_select_o),
    .spk_oe(speaker_or_base_select_oe), .sclk(sclk), .io_lvl(io_wide_select_n_i),
    .rdy_lvl(channel_ready_i), .mem_lvl(mem_wide_select_i), .zw_lvl(zero_wait_n_i),
    .spk_lvl(speaker_or_base_select_i));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Inputs change 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Host cycle; strobe held while ready is low
  task automatic cyc(input logic io, input logic wr, input logic hi, input logic [15:0] d);
    int i;
    sys_d_i = d;
    hit = 1'b1;
    hit_io = io;
    strobe.sbhe_n = !hi;
    addr_odd = hi;
    {strobe.memr_n, strobe.memw_n, strobe.ior_n, strobe.iow_n} = ~(4'h1 << {!io, !wr});
    rdy = 1'b0;
    for (i = 0; i < 80 && !(card_rd || card_wr); i++) begin
      tick(1);
      if (channel_ready_i === 1'b0) rdy = 1'b1;
    end
    if (i == 80) begin
      fail_count++;
      end_of_test();
    end
    zw = !zero_wait_n_i;
    chk(card_byte_en, {14'h0, hi, !hi});
    chk({card_rd, card_wr}, {!wr, wr});
    if (wr) chk(card_wdata, d);
    tick(1);
    if (!wr) chk({sys_d_oe, sys_d_o}, {1'b1, card_rdata});
    strobe = SB_IDLE;
    tick(3);
    chk({card_rd, card_wr}, 2'h0);
    hit = 1'b0;
  endtask : cyc
  ////////////////////////////////////////////////////////////////////////////////
  // Zero-wait: enabled only, never 16-bit I/O
  task automatic t_cycles();
    zero_wait_en = 1'b1;
    cyc(1'b0, 1'b1, 1'b1, 16'ha55a);
    chk(zw, 1'b1);
    cyc(1'b0, 1'b0, 1'b0, 16'h0000);
    chk(zw, 1'b1);
    card[0].io_wide = 1'b1;
    cyc(1'b1, 1'b1, 1'b0, 16'h3cc3);
    chk(zw, 1'b0);
    card[0].io_wide = 1'b0;
    cyc(1'b1, 1'b0, 1'b1, 16'h0001);
    chk(zw, 1'b1);
    zero_wait_en = 1'b0;
    cyc(1'b0, 1'b0, 1'b1, 16'h0002);
    chk(zw, 1'b0);
    wait_state_en = 1'b1;
    zero_wait_en = 1'b1;
    cyc(1'b0, 1'b0, 1'b1, 16'h0003);
    chk({rdy, zw}, 2'b10);
    wait_state_en = 1'b0;
  endtask : t_cycles
  // Width indications and address-enable refusal
  task automatic t_width();
    hit = 1'b1;
    hit_io = 1'b0;
    tick(2);
    chk(mem_wide_select_i, 1'b0);
    card[0].mem_wide = 1'b1;
    tick(2);
    chk(mem_wide_select_i, 1'b1);
    hit_io = 1'b1;
    card[0].io_wide = 1'b1;
    tick(2);
    chk(io_wide_select_n_i, 1'b0);
    strobe.aen = 1'b1;
    strobe.ior_n = 1'b0;
    tick(6);
    chk({io_wide_select_n_i, card_rd, card_wr}, 3'b100);
    strobe = SB_IDLE;
    hit = 1'b0;
    card[0].io_wide = 1'b0;
    tick(3);
  endtask : t_width
  // Each interrupt number; other slot unlisted
  task automatic t_irq();
    irq_sel[1] = 4'h6;
    card[1].irq = 1'b1;
    card[0].irq = 1'b1;
    for (int i = 0; i < IHS_IRQ_LINES; i++) begin
      irq_sel[0] = IHS_IRQ_NUM[i];
      tick(2);
      chk({6'h0, irq_req}, 16'h1 << i);
    end
    card = {2{5'b00110}};
  endtask : t_irq
  // Check pulse length in system clocks
  task automatic t_check();
    int n;
    check_req = 1'b1;
    tick(1);
    check_req = 1'b0;
    for (n = 0; n < 40 && channel_check_n !== 1'b0; n++) tick(1);
    for (n = 0; n < 60 && channel_check_n === 1'b0; n++) tick(1);
    chk(n, IHS_CHECK_PERIODS * 8);
  endtask : t_check
  // Speaker audio on the shared pin
  task automatic t_spk();
    speaker_en = 2'b01;
    card[0].spkr_n = 1'b0;
    tick(2);
    chk(speaker_or_base_select_i, 1'b1);
    speaker_en = 2'b11;
    card[1].spkr_n = 1'b0;
    tick(2);
    chk(speaker_or_base_select_i, 1'b0);
  endtask : t_spk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, hit, hit_io, hit_slot, addr_odd, zero_wait_en, wait_state_en, check_req} = '0;
    {fail_count, n_tests, irq_sel, speaker_en, sys_d_i} = '0;
    system_reset_in = 1'b1;
    strap = 1'b1;
    strobe = SB_IDLE;
    card = {2{5'b00110}};
    card_rdata = 16'hc35a;
    tick(8);
    arst_n = 1'b1;
    tick(3);
    chk(base_select, 1'b1);
    system_reset_in = 1'b0;
    tick(2);
    chk(speaker_or_base_select_oe, 1'b1);
    t_cycles();
    t_width();
    t_irq();
    t_check();
    t_spk();
    end_of_test();
  end
endmodule : testbench
bind ihs_host_port ihs_host_port_assertions #(.SLOTS(SLOTS), .WAIT_PERIODS(WAIT_PERIODS),
  .SLOT_W(SLOT_W)) i_chk (.*);
